// file: design/tacb_bank.sv
// Purpose: Timer-two control, auxiliary control, pointer bank and power flag
//          registers on APB, with the control outputs they steer.
// Assumes: Byte address is four times the register index; 8-bit data.
// Notes:   Power-off flag lives on its own power-up reset input.
//          Writes land at the edge where ready is seen high.
//
// Functional notes
// R1 - Unmapped addresses read zero, writes dropped.
// R2 - Software writes no ones to unlisted bits.
// R3 - Overflow flag set by hardware, not when baud.
// R4 - External flag set on enabled trigger fall.
// R5 - External flag requests interrupt unless up/down mode.
// R6 - Receive-clock select picks timer-two overflow source.
// R7 - Transmit-clock select picks timer-two overflow source.
// R8 - Trigger enable gates edges unless baud mode.
// R9 - Run-control bit starts and stops timer two.
// R10 - Counter select chooses ticks or external edges.
// R11 - Capture/reload select chooses trigger action.
// R12 - Baud mode forces auto-reload, ignores select.
// R13 - Byte pair forms 16-bit capture/reload value.
// R14 - Strobe disable: continuous strobe or only moves. Here the disabled strobe also runs during external execution.
// R15 - Expanded RAM select routes external data moves.
// R16 - Two pointer banks chosen by select bit.
// R17 - Software sets bank select before pointer use.
// R18 - Power-off flag set at power-up, reset-proof.
// R19 - Six sources: enable and priority bits each.
// R20 - Reset pin driven 98 periods after watchdog timeout.
// R21 - Watchdog idle-halt stops watchdog while idle.
// R22 - Auxiliary reserved bits unspecified; read zero here.
`timescale 1ns/1ps
`include "tacb_defs.svh"

module tacb_bank (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_ARST_N,
	input  wire logic        I_POWER_UP_N,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [11:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	input  wire logic        I_T2_OVERFLOW,
	input  wire logic        I_T2_TRIGGER_PIN,
	input  wire logic        I_T2_CAPTURE_EVT,
	input  wire logic [15:0] I_T2_COUNT,
	input  wire logic        I_T1_OVERFLOW,
	input  wire logic        I_MOVE_ACTIVE,
	input  wire logic        I_WATCHDOG_TIMEOUT,
	input  wire logic        I_IDLE,
	input  wire logic        I_EXT_EXEC,
	output logic             O_T2_RUN,
	output logic             O_T2_COUNT_EXTERNAL,
	output logic             O_T2_CAPTURE_MODE,
	output logic             O_T2_TRIGGER_EVENT,
	output logic             O_T2_DOWN_ENABLE,
	output logic      [15:0] O_T2_RELOAD_VALUE,
	output logic             O_T2_IRQ,
	output logic             O_SERIAL_RX_CLK,
	output logic             O_SERIAL_TX_CLK,
	output logic             O_STROBE,
	output logic             O_EXPANDED_RAM_SEL,
	output logic      [15:0] O_POINTER,
	output logic             O_RESET_OUT,
	output logic             O_RESET_OUT_OE,
	output logic             O_WATCHDOG_COUNT_EN,
	output logic      [5:0]  O_IRQ_ENABLE,
	output logic      [5:0]  O_IRQ_PRIORITY,
	output logic             O_POWER_OFF_FLAG
);

	logic            rst_meta_q;
	logic            rst_sync_q;
	logic            trig_meta_q;
	logic            trig_sync_q;
	logic            trig_prev_q;
	logic            rsto_meta_q;
	logic            rsto_sync_q;
	logic            rsto_prev_q;
	logic            pwr_meta_q;
	logic            pwr_sync_q;
	tacb_pkg::tacb_byte_t timer2_control_q;
	tacb_pkg::tacb_byte_t t2mode_q;
	tacb_pkg::tacb_byte_t aux_q;
	tacb_pkg::tacb_byte_t cap_lo_q;
	tacb_pkg::tacb_byte_t cap_hi_q;
	tacb_pkg::tacb_byte_t ie_q;
	tacb_pkg::tacb_byte_t ip_q;
	tacb_pkg::tacb_byte_t power_control_q;
	tacb_pkg::tacb_byte_t ptr_q [4];
	logic            bank_sel_q;
	logic            pof_q;
	logic [2:0]      strobe_cnt_q;
	logic [6:0]      rsto_cnt_q;
	logic [7:0]      rdata_d;
	logic [7:0]      idx;
	logic [7:0]      wbyte;
	logic            wr_en;
	logic            rd_en;
	logic            baud_mode;
	logic            trig_fall;
	logic            trig_event;
	logic            wr_timer2_control;

	// Reset release through two flip-flops.
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	// Power-up reset release through its own two flip-flops, so the
	// power-off flag leaves reset cleanly and ordinary resets miss it.
	always_ff @(posedge I_REF_CLK or negedge I_POWER_UP_N) begin
		if (!I_POWER_UP_N) begin
			pwr_meta_q <= 1'b0;
			pwr_sync_q <= 1'b0;
		end else begin
			pwr_meta_q <= 1'b1;
			pwr_sync_q <= pwr_meta_q;
		end
	end

	// Trigger pin and watchdog timeout cross in through two flip-flops.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			trig_meta_q <= 1'b1;
			trig_sync_q <= 1'b1;
			trig_prev_q <= 1'b1;
			rsto_meta_q <= 1'b0;
			rsto_sync_q <= 1'b0;
			rsto_prev_q <= 1'b0;
		end else begin
			trig_meta_q <= I_T2_TRIGGER_PIN;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
			rsto_meta_q <= I_WATCHDOG_TIMEOUT;
			rsto_sync_q <= rsto_meta_q;
			rsto_prev_q <= rsto_sync_q;
		end
	end

	// Bus decode: index is the word address; one wait state.
	assign idx   = I_PADDR[9:2];
	assign wbyte = I_PWDATA[7:0];
	// A write lands only at the access edge where ready is high.
	assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && O_PREADY;
	assign rd_en = I_PSEL && I_PENABLE && !I_PWRITE;

	// Baud mode and trigger qualification.
	assign baud_mode = timer2_control_q[`TACB_T2_RXCLK_BIT] ||
		timer2_control_q[`TACB_T2_TXCLK_BIT];                   // [R12]
	assign trig_fall = trig_prev_q && !trig_sync_q;
	assign trig_event = trig_fall && timer2_control_q[`TACB_T2_EXTEN_BIT] &&
		!baud_mode;                                    // [R8]
	assign wr_timer2_control = wr_en && (idx == `TACB_IDX_T2_CONTROL);

	// Timer-two control: software writes, hardware sets flags; set wins.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			timer2_control_q <= `TACB_RST_BYTE;
		end else begin
			if (wr_timer2_control) begin
				timer2_control_q <= wbyte;                      // [R9] [R10] [R11]
			end
			if (I_T2_OVERFLOW && !baud_mode) begin
				timer2_control_q[`TACB_T2_OVF_BIT] <= 1'b1;     // [R3]
			end
			if (trig_event) begin
				timer2_control_q[`TACB_T2_EXT_BIT] <= 1'b1;     // [R4]
			end
		end
	end

	// Capture/reload pair: loaded by software or by a capture.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			cap_lo_q <= `TACB_RST_BYTE;
			cap_hi_q <= `TACB_RST_BYTE;
		end else if (I_T2_CAPTURE_EVT) begin
			cap_lo_q <= I_T2_COUNT[7:0];                // [R13]
			cap_hi_q <= I_T2_COUNT[15:8];               // [R13]
		end else if (wr_en && idx == `TACB_IDX_CAP_LO) begin
			cap_lo_q <= wbyte;
		end else if (wr_en && idx == `TACB_IDX_CAP_HI) begin
			cap_hi_q <= wbyte;
		end
	end

	// Mode, auxiliary, interrupt and pointer-bank registers.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			t2mode_q   <= `TACB_RST_BYTE;
			aux_q      <= `TACB_RST_BYTE;
			ie_q       <= `TACB_RST_BYTE;
			ip_q       <= `TACB_RST_BYTE;
			power_control_q     <= `TACB_RST_BYTE;
			bank_sel_q <= 1'b0;
		end else if (wr_en) begin
			case (idx)
				`TACB_IDX_T2_MODE: begin
					t2mode_q <= wbyte & `TACB_T2MODE_WMASK;
				end
				`TACB_IDX_AUX_CONTROL: begin
					aux_q <= wbyte & `TACB_AUX_WMASK;  // [R22]
				end
				`TACB_IDX_IE: begin
					ie_q <= wbyte & `TACB_IE_WMASK;    // [R19]
				end
				`TACB_IDX_IP: begin
					ip_q <= wbyte & `TACB_IP_WMASK;    // [R19]
				end
				`TACB_IDX_POWER_CONTROL: begin
					power_control_q <= wbyte & `TACB_POWER_CONTROL_WMASK;
				end
				`TACB_IDX_PTR_BANK_CTRL: begin
					bank_sel_q <= wbyte[0];            // [R16]
				end
				default: begin
				end
			endcase
		end
	end

	// Pointer banks: four bytes, one per printed index.
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ptr
			always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
				if (!rst_sync_q) begin
					ptr_q[g] <= `TACB_RST_BYTE;
				end else if (wr_en && idx ==
					8'(`TACB_IDX_PTR0_LO + g)) begin
					ptr_q[g] <= wbyte;                 // [R16]
				end
			end
		end
	endgenerate

	// Power-off flag and its output copy: only power-up presets them;
	// system reset leaves both alone.
	always_ff @(posedge I_REF_CLK or negedge pwr_sync_q) begin
		if (!pwr_sync_q) begin
			pof_q            <= 1'b1;                  // [R18]
			O_POWER_OFF_FLAG <= 1'b1;
		end else begin
			if (wr_en && idx == `TACB_IDX_POWER_CONTROL) begin
				pof_q <= wbyte[`TACB_POF_BIT];         // [R18]
			end
			O_POWER_OFF_FLAG <= pof_q;              // [R18]
		end
	end

	// Read multiplexer; unlisted indices read zero.
	always_comb begin
		rdata_d = `TACB_RST_BYTE;
		case (idx)
			`TACB_IDX_T2_CONTROL:   rdata_d = timer2_control_q;
			`TACB_IDX_T2_MODE:      rdata_d = t2mode_q;
			`TACB_IDX_CAP_LO:       rdata_d = cap_lo_q;
			`TACB_IDX_CAP_HI:       rdata_d = cap_hi_q;
			`TACB_IDX_T2_COUNT_LO:  rdata_d = I_T2_COUNT[7:0];
			`TACB_IDX_T2_COUNT_HI:  rdata_d = I_T2_COUNT[15:8];
			`TACB_IDX_AUX_CONTROL:  rdata_d = aux_q;
			`TACB_IDX_IE:           rdata_d = ie_q;
			`TACB_IDX_IP:           rdata_d = ip_q;
			`TACB_IDX_PTR_BANK_CTRL: rdata_d = {7'h00, bank_sel_q};
			`TACB_IDX_POWER_CONTROL: begin
				rdata_d = power_control_q;
				rdata_d[`TACB_POF_BIT] = pof_q;
			end
			`TACB_IDX_PTR0_LO:      rdata_d = ptr_q[0];
			`TACB_IDX_PTR0_HI:      rdata_d = ptr_q[1];
			`TACB_IDX_PTR1_LO:      rdata_d = ptr_q[2];
			`TACB_IDX_PTR1_HI:      rdata_d = ptr_q[3];
			default:                rdata_d = `TACB_RST_BYTE; // [R1]
		endcase
	end

	// Bus answer registered: ready one cycle into the access phase.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			O_PRDATA  <= 32'h0000_0000;
			O_PREADY  <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY  <= I_PSEL && I_PENABLE && !O_PREADY;
			O_PSLVERR <= 1'b0;
			O_PRDATA  <= rd_en ? {24'h000000, rdata_d} : 32'h0000_0000;
		end
	end

	// Address strobe: every sixth clock, or only during moves or external execution.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			strobe_cnt_q <= 3'h0;
			O_STROBE     <= 1'b0;
		end else begin
			strobe_cnt_q <= (strobe_cnt_q == 3'(`TACB_STROBE_DIV - 1)) ?
				3'h0 : strobe_cnt_q + 3'h1;
			O_STROBE <= (strobe_cnt_q == 3'h0) &&
				(!aux_q[`TACB_AUX_STROBE_DIS_BIT] || I_MOVE_ACTIVE ||
				I_EXT_EXEC);                           // [R14]
		end
	end

	// Reset-out pulse counter after a watchdog timeout.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rsto_cnt_q     <= 7'h00;
			O_RESET_OUT    <= 1'b0;
			O_RESET_OUT_OE <= 1'b0;
		end else begin
			if (rsto_sync_q && !rsto_prev_q &&
				!aux_q[`TACB_AUX_RSTO_DIS_BIT]) begin
				rsto_cnt_q <= 7'(`TACB_RSTO_CYCLES);   // [R20]
			end else if (rsto_cnt_q != 7'h00) begin
				rsto_cnt_q <= rsto_cnt_q - 7'h01;
			end
			O_RESET_OUT    <= (rsto_cnt_q != 7'h00); // [R20]
			O_RESET_OUT_OE <= (rsto_cnt_q != 7'h00);
		end
	end

	// Registered control outputs steered by the registers.
	always_ff @(posedge I_REF_CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			O_T2_RUN            <= 1'b0;
			O_T2_COUNT_EXTERNAL <= 1'b0;
			O_T2_CAPTURE_MODE   <= 1'b0;
			O_T2_TRIGGER_EVENT  <= 1'b0;
			O_T2_DOWN_ENABLE    <= 1'b0;
			O_T2_RELOAD_VALUE   <= 16'h0000;
			O_T2_IRQ            <= 1'b0;
			O_SERIAL_RX_CLK     <= 1'b0;
			O_SERIAL_TX_CLK     <= 1'b0;
			O_EXPANDED_RAM_SEL  <= 1'b0;
			O_POINTER           <= 16'h0000;
			O_WATCHDOG_COUNT_EN <= 1'b1;
			O_IRQ_ENABLE        <= 6'h00;
			O_IRQ_PRIORITY      <= 6'h00;
		end else begin
			O_T2_RUN <= timer2_control_q[`TACB_T2_RUN_BIT];     // [R9]
			O_T2_COUNT_EXTERNAL <= timer2_control_q[`TACB_T2_CT_BIT]; // [R10]
			O_T2_CAPTURE_MODE <= timer2_control_q[`TACB_T2_CPRL_BIT] &&
				!baud_mode;                            // [R11] [R12]
			O_T2_TRIGGER_EVENT <= trig_event;          // [R8]
			O_T2_DOWN_ENABLE <= t2mode_q[`TACB_T2MODE_T2_COUNT_DIRECTION_ENABLE_BIT];
			O_T2_RELOAD_VALUE <= {cap_hi_q, cap_lo_q}; // [R13]
			O_T2_IRQ <= ie_q[`TACB_IE_ALL_BIT] && ie_q[`TACB_IE_T2_BIT] &&
				(timer2_control_q[`TACB_T2_OVF_BIT] ||
				(timer2_control_q[`TACB_T2_EXT_BIT] &&
				!t2mode_q[`TACB_T2MODE_T2_COUNT_DIRECTION_ENABLE_BIT]));    // [R5]
			O_SERIAL_RX_CLK <= timer2_control_q[`TACB_T2_RXCLK_BIT] ?
				I_T2_OVERFLOW : I_T1_OVERFLOW;         // [R6]
			O_SERIAL_TX_CLK <= timer2_control_q[`TACB_T2_TXCLK_BIT] ?
				I_T2_OVERFLOW : I_T1_OVERFLOW;         // [R7]
			O_EXPANDED_RAM_SEL <= !aux_q[`TACB_AUX_XRAM_BIT]; // [R15]
			O_POINTER <= bank_sel_q ? {ptr_q[3], ptr_q[2]} :
				{ptr_q[1], ptr_q[0]};                  // [R16] [R17]
			O_WATCHDOG_COUNT_EN <= !(I_IDLE &&
				aux_q[`TACB_AUX_WD_IDLE_BIT]);         // [R21]
			O_IRQ_ENABLE   <= ie_q[5:0];               // [R19]
			O_IRQ_PRIORITY <= ip_q[5:0];               // [R19]
		end
	end

endmodule // tacb_bank

// file: design/tacb_defs.svh
// Purpose: Offsets, bit positions, reset values and timing for the bank.
// Assumes: APB byte addresses are four times the printed register index.
// Notes:   Included by the package and by the bank itself.
`ifndef TACB_DEFS_SVH
`define TACB_DEFS_SVH

// Register indices as printed in the register-space map.
`define TACB_IDX_PTR0_LO        8'h82
`define TACB_IDX_PTR0_HI        8'h83
`define TACB_IDX_PTR1_LO        8'h84
`define TACB_IDX_PTR1_HI        8'h85
`define TACB_IDX_POWER_CONTROL  8'h87
`define TACB_IDX_AUX_CONTROL    8'h8e
`define TACB_IDX_PTR_BANK_CTRL  8'ha2
`define TACB_IDX_IE             8'ha8
`define TACB_IDX_IP             8'hb8
`define TACB_IDX_T2_CONTROL     8'hc8
`define TACB_IDX_CAP_LO         8'hca
`define TACB_IDX_CAP_HI         8'hcb
`define TACB_IDX_T2_MODE        8'hc9
`define TACB_IDX_T2_COUNT_LO    8'hcc
`define TACB_IDX_T2_COUNT_HI    8'hcd

// Timer-two control bit positions.
`define TACB_T2_OVF_BIT         7
`define TACB_T2_EXT_BIT         6
`define TACB_T2_RXCLK_BIT       5
`define TACB_T2_TXCLK_BIT       4
`define TACB_T2_EXTEN_BIT       3
`define TACB_T2_RUN_BIT         2
`define TACB_T2_CT_BIT          1
`define TACB_T2_CPRL_BIT        0

// Auxiliary control bit positions.
`define TACB_AUX_STROBE_DIS_BIT 0
`define TACB_AUX_XRAM_BIT       1
`define TACB_AUX_RSTO_DIS_BIT   3
`define TACB_AUX_WD_IDLE_BIT    4
`define TACB_AUX_WMASK          8'h1b

// Other field positions and masks.
`define TACB_POF_BIT            4
`define TACB_T2MODE_T2_COUNT_DIRECTION_ENABLE_BIT    0
`define TACB_T2MODE_WMASK       8'h03
`define TACB_IE_T2_BIT          5
`define TACB_IE_ALL_BIT         7
`define TACB_IE_WMASK           8'hbf
`define TACB_IP_WMASK           8'h3f
`define TACB_POWER_CONTROL_WMASK         8'h9f

// Reset values.
`define TACB_RST_BYTE           8'h00

// Reset-out pulse: 98 oscillator periods, oscillator taken as the clock.
`define TACB_RSTO_PERIODS       98
`define TACB_RSTO_CYCLES        (`TACB_RSTO_PERIODS)
// Address strobe divide ratio (one strobe per six oscillator periods).
`define TACB_STROBE_DIV         6

`endif

// file: design/tacb_pkg.sv
// Purpose: Types shared by the timer-two and auxiliary control bank.
// Assumes: Constants come from tacb_defs.svh.
// Notes:   Nothing here is imported; users write tacb_pkg::name.
`include "tacb_defs.svh"
package tacb_pkg;
	// APB transfer phase of the slave.
	typedef enum logic [1:0] {
		TACB_IDLE   = 2'b00,
		TACB_ACCESS = 2'b01
	} tacb_phase_t;
	typedef logic [7:0] tacb_byte_t;
endpackage

// file: dv/tacb_bank_properties.sv
// Purpose: Port-level properties of the timer-two and aux control bank.
// Assumes: Bound to tacb_bank; a single clock domain.
// Notes:   A helper counter measures the reset-out pulse length.
`timescale 1ns/1ps
`include "tacb_defs.svh"
module tacb_bank_properties (
	input wire logic        I_REF_CLK,
	input wire logic        I_ARST_N,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [31:0] O_PRDATA,
	input wire logic        O_PREADY,
	input wire logic        I_T2_OVERFLOW,
	input wire logic        I_T1_OVERFLOW,
	input wire logic        I_IDLE,
	input wire logic        O_T2_RUN,
	input wire logic        O_SERIAL_RX_CLK,
	input wire logic        O_SERIAL_TX_CLK,
	input wire logic        O_STROBE,
	input wire logic        O_RESET_OUT,
	input wire logic        O_RESET_OUT_OE,
	input wire logic        O_WATCHDOG_COUNT_EN,
	input wire logic        O_POWER_OFF_FLAG
);
	logic [7:0] hi_cnt_q;
	logic       apb_wr;
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_ARST_N);
	// Counts consecutive cycles with the reset pin driven high.
	always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
		if (!I_ARST_N)
			hi_cnt_q <= 8'h00;
		else
			hi_cnt_q <= O_RESET_OUT ? hi_cnt_q + 8'h01 : 8'h00;
	end
	// Marks an APB write in its access phase.
	assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
	a_ready_after_access: assert property ($rose(I_PENABLE) && I_PSEL
		|=> O_PREADY) else $error("ready not one cycle after access");
	a_rdata_upper_zero: assert property (O_PREADY
		|-> O_PRDATA[31:8] == 24'h000000) else $error("upper data set");
	a_strobe_spacing: assert property (O_STROBE
		|=> !O_STROBE [*5]) else $error("strobe closer than six clocks");
	a_rx_clk_cause: assert property (O_SERIAL_RX_CLK
		|-> $past(I_T2_OVERFLOW || I_T1_OVERFLOW)) else $error("stray rx");
	a_tx_clk_cause: assert property (O_SERIAL_TX_CLK
		|-> $past(I_T2_OVERFLOW || I_T1_OVERFLOW)) else $error("stray tx");
	a_reset_out_len: assert property ($fell(O_RESET_OUT)
		|-> int'(hi_cnt_q) == `TACB_RSTO_CYCLES) else $error("bad pulse");
	a_reset_oe_pair: assert property (O_RESET_OUT_OE == O_RESET_OUT)
		else $error("reset pin enable differs from level");
	a_watchdog_runs: assert property (!I_IDLE ##1 !I_IDLE
		|=> O_WATCHDOG_COUNT_EN) else $error("watchdog halted outside idle");
	a_run_by_write: assert property ($changed(O_T2_RUN)
		|-> $past(apb_wr) || $past(apb_wr, 2)) else $error("run changed");
	a_pof_kept: assert property ($changed(O_POWER_OFF_FLAG)
		&& $past(I_ARST_N, 6) |-> $past(apb_wr) || $past(apb_wr, 2))
		else $error("power-off flag changed without a write");
endmodule // tacb_bank_properties

bind tacb_bank tacb_bank_properties i_props (
	.I_REF_CLK(I_REF_CLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL),
	.I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .O_PRDATA(O_PRDATA),
	.O_PREADY(O_PREADY), .I_T2_OVERFLOW(I_T2_OVERFLOW),
	.I_T1_OVERFLOW(I_T1_OVERFLOW), .I_IDLE(I_IDLE), .O_T2_RUN(O_T2_RUN),
	.O_SERIAL_RX_CLK(O_SERIAL_RX_CLK), .O_SERIAL_TX_CLK(O_SERIAL_TX_CLK),
	.O_STROBE(O_STROBE), .O_RESET_OUT(O_RESET_OUT),
	.O_RESET_OUT_OE(O_RESET_OUT_OE),
	.O_WATCHDOG_COUNT_EN(O_WATCHDOG_COUNT_EN),
	.O_POWER_OFF_FLAG(O_POWER_OFF_FLAG)
);

// file: dv/tacb_cpu_model.sv
// Purpose: CPU-side model that issues APB register transfers.
// Assumes: One transfer at a time; ready is sampled at rising edges.
// Notes:   Waits for ready as long as needed; the bench watchdog bounds it.
`timescale 1ns/1ps
module tacb_cpu_model (
	input  wire logic        clk,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic      [11:0] paddr,
	output logic      [31:0] pwdata
);
	// The bus starts idle.
	initial {psel, penable, pwrite, paddr, pwdata} = '0;
	// One setup and access transfer; returns the low data byte.
	task automatic xfer(input logic wr, input logic [7:0] idx,
		input logic [7:0] wd, output logic [7:0] rd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		// The request holds until ready is seen at a rising edge.
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata[7:0];
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
endmodule // tacb_cpu_model

// file: dv/timer2_aux_control_sfr_bank_tb_top.sv
// Purpose: Directed register and control-output tests of tacb_bank.
// Assumes: Byte address is four times the register index.
// Notes:   Inputs change by non-blocking assignment at rising edges.
`timescale 1ns/1ps
`include "tacb_defs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
	$display("wrong value at %0t: got %0h, expected %0h", $time, g, e); end end
module timer2_aux_control_sfr_bank_tb_top;
	logic        clk, arst_n, pwrup_n, psel, penable, pwrite, pready;
	logic        t2_ovf, trig, cap_evt, t1_ovf, move, wdt_to, idle;
	logic        ext_exec, pslverr, run, cnt_ext, cap_mode, trig_evt;
	logic        down_en, irq, rx_clk, tx_clk, strobe, eram_sel;
	logic        rst_out, rst_oe, wd_en, power_off_flag;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [15:0] t2_cnt, reload, pointer;
	logic [5:0]  irq_en, irq_pri;
	logic [1:0]  s;
	int          n_errors, n_compared, c;
	tacb_bank i_dut (.I_REF_CLK(clk), .I_ARST_N(arst_n),
		.I_POWER_UP_N(pwrup_n), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_T2_OVERFLOW(t2_ovf), .I_T2_TRIGGER_PIN(trig),
		.I_T2_CAPTURE_EVT(cap_evt), .I_T2_COUNT(t2_cnt),
		.I_T1_OVERFLOW(t1_ovf), .I_MOVE_ACTIVE(move),
		.I_WATCHDOG_TIMEOUT(wdt_to), .I_IDLE(idle), .I_EXT_EXEC(ext_exec),
		.O_T2_RUN(run), .O_T2_COUNT_EXTERNAL(cnt_ext),
		.O_T2_CAPTURE_MODE(cap_mode), .O_T2_TRIGGER_EVENT(trig_evt),
		.O_T2_DOWN_ENABLE(down_en), .O_T2_RELOAD_VALUE(reload),
		.O_T2_IRQ(irq), .O_SERIAL_RX_CLK(rx_clk), .O_SERIAL_TX_CLK(tx_clk),
		.O_STROBE(strobe), .O_EXPANDED_RAM_SEL(eram_sel),
		.O_POINTER(pointer), .O_RESET_OUT(rst_out),
		.O_RESET_OUT_OE(rst_oe), .O_WATCHDOG_COUNT_EN(wd_en),
		.O_IRQ_ENABLE(irq_en), .O_IRQ_PRIORITY(irq_pri),
		.O_POWER_OFF_FLAG(power_off_flag));
	tacb_cpu_model i_cpu (.clk(clk), .prdata(prdata), .pready(pready),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata));
	// Free-running 100 MHz clock.
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] r;
		i_cpu.xfer(1'b1, idx, d, r);
		// Lets the steered outputs take up the new register value.
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
		logic [7:0] r;
		i_cpu.xfer(1'b0, idx, 8'h00, r);
		`CHK(r, e)
	endtask
	// Counts strobe, reset-out or trigger-event cycles over n clocks.
	task automatic cnt(input int sel, input int n, output int k);
		k = 0;
		repeat (n) begin
			@(posedge clk);
			k += int'((sel == 0 ? strobe : sel == 1 ? rst_out :
				trig_evt) === 1'b1);
		end
	endtask
	// Falling edge on the trigger pin; counts the resulting events.
	task automatic fall(output int k);
		trig <= 1'b0;
		cnt(2, 8, k);
		trig <= 1'b1;
		repeat (6) @(posedge clk);
	endtask
	// One overflow pulse from each selected timer; returns {rx, tx}.
	task automatic ovf(input logic a, input logic b, output logic [1:0] r);
		t1_ovf <= a;
		t2_ovf <= b;
		@(posedge clk);
		{t1_ovf, t2_ovf} <= 2'b00;
		@(posedge clk);
		r = {rx_clk, tx_clk};
	endtask
	task automatic summarize();
		$display("compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// Cuts a hung run short.
	initial begin
		#100us;
		n_errors++;
		summarize();
	end
	// Main sequence of tests.
	initial begin
		{t2_ovf, cap_evt, t2_cnt, t1_ovf, move, wdt_to, idle, ext_exec} = '0;
		{trig, arst_n, pwrup_n} = 3'b100;
		repeat (10) @(posedge clk);
		{arst_n, pwrup_n} <= 2'b11;
		repeat (3) @(posedge clk);
		rchk(`TACB_IDX_T2_CONTROL, 8'h00);
		rchk(`TACB_IDX_AUX_CONTROL, 8'h00);
		arst_n <= 1'b0;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		rchk(`TACB_IDX_POWER_CONTROL, 8'h10);
		wr(`TACB_IDX_POWER_CONTROL, 8'h00);
		rchk(`TACB_IDX_POWER_CONTROL, 8'h00);
		`CHK(power_off_flag, 1'b0)
		wr(8'h8f, 8'h00);
		rchk(8'h8f, 8'h00);
		`CHK(pslverr, 1'b0)
		$display("test reset and unmapped done");
		wr(`TACB_IDX_AUX_CONTROL, 8'hff);
		rchk(`TACB_IDX_AUX_CONTROL, 8'h1b);
		`CHK(eram_sel, 1'b0)
		cnt(0, 24, c);
		`CHK(c, 0)
		move <= 1'b1;
		cnt(0, 24, c);
		`CHK(c > 0, 1'b1)
		{move, idle, wdt_to} <= 3'b011;
		cnt(1, 110, c);
		`CHK(c, 0)
		`CHK(wd_en, 1'b0)
		wdt_to <= 1'b0;
		wr(`TACB_IDX_AUX_CONTROL, 8'h00);
		`CHK({eram_sel, wd_en}, 2'b11)
		{idle, wdt_to} <= 2'b01;
		cnt(1, 110, c);
		`CHK(c, `TACB_RSTO_CYCLES)
		wdt_to <= 1'b0;
		cnt(0, 24, c);
		`CHK(c, 4)
		$display("test aux control done");
		wr(`TACB_IDX_T2_CONTROL, 8'h0f);
		`CHK({run, cnt_ext, cap_mode}, 3'b111)
		ovf(1'b0, 1'b1, s);
		rchk(`TACB_IDX_T2_CONTROL, 8'h8f);
		fall(c);
		`CHK(c, 1)
		rchk(`TACB_IDX_T2_CONTROL, 8'hcf);
		wr(`TACB_IDX_IE, 8'ha0);
		`CHK({irq, irq_en}, 7'h60)
		wr(`TACB_IDX_T2_CONTROL, 8'h0a);
		rchk(`TACB_IDX_T2_CONTROL, 8'h0a);
		`CHK({run, irq}, 2'b00)
		wr(`TACB_IDX_T2_MODE, 8'h01);
		fall(c);
		rchk(`TACB_IDX_T2_CONTROL, 8'h4a);
		`CHK({down_en, irq}, 2'b10)
		wr(`TACB_IDX_T2_CONTROL, 8'h02);
		`CHK({cnt_ext, cap_mode}, 2'b10)
		fall(c);
		`CHK(c, 0)
		$display("test timer control done");
		wr(`TACB_IDX_T2_CONTROL, 8'h29);
		`CHK(cap_mode, 1'b0)
		ovf(1'b0, 1'b1, s);
		`CHK(s, 2'b10)
		ovf(1'b1, 1'b0, s);
		`CHK(s, 2'b01)
		fall(c);
		`CHK(c, 0)
		wr(`TACB_IDX_T2_CONTROL, 8'h10);
		ovf(1'b0, 1'b1, s);
		`CHK(s, 2'b01)
		rchk(`TACB_IDX_T2_CONTROL, 8'h10);
		$display("test baud clocks done");
		t2_cnt <= 16'ha55a;
		cap_evt <= 1'b1;
		@(posedge clk);
		cap_evt <= 1'b0;
		rchk(`TACB_IDX_CAP_LO, 8'h5a);
		rchk(`TACB_IDX_CAP_HI, 8'ha5);
		wr(`TACB_IDX_CAP_HI, 8'h12);
		`CHK(reload, 16'h125a)
		for (int i = 0; i < 4; i++)
			wr(8'(`TACB_IDX_PTR0_LO + i), 8'(17 * i + 17));
		wr(`TACB_IDX_PTR_BANK_CTRL, 8'h00);
		`CHK(pointer, 16'h2211)
		wr(`TACB_IDX_PTR_BANK_CTRL, 8'h01);
		`CHK(pointer, 16'h4433)
		wr(`TACB_IDX_IP, 8'hff);
		rchk(`TACB_IDX_IP, 8'h3f);
		`CHK(irq_pri, 6'h3f)
		$display("test capture, pointers and priority done");
		summarize();
	end
endmodule // timer2_aux_control_sfr_bank_tb_top
